// ===== rtl/ldsr_pkg.sv
package ldsr_pkg;

  // link frame layout, first bit received is bit 16
  localparam int FRAME_BITS = 17;
  localparam int FRM_TYPE_POS = 16;
  localparam int FRM_CODE_MSB = 15;
  localparam int FRM_CODE_LSB = 11;
  localparam int FRM_SEL_MSB = 10;
  localparam int FRM_SEL_LSB = 3;

  // command codes
  localparam logic [4:0] CMD_RD_DATA = 5'h19;
  localparam logic [4:0] CMD_WR_RST = 5'h1A;
  localparam logic [4:0] CMD_WR_START = 5'h1B;

  // select bit of each register in the read-data select byte
  localparam int SEL_FAULT_9_12 = 2;
  localparam int SEL_FAULT_13_16 = 3;
  localparam int SEL_FAULT_17_18 = 4;
  localparam int SEL_GENERAL = 5;

  // fault codes per channel, two bits each
  localparam logic [1:0] FC_OK = 2'h3;
  localparam logic [1:0] FC_SCB_DOT = 2'h2;
  localparam logic [1:0] FC_OPEN = 2'h1;
  localparam logic [1:0] FC_SCG = 2'h0;

  // field positions in the channel 17/18 register
  localparam int F17_REVCUR = 4;
  localparam int F17_CH15 = 5;
  localparam int F17_CH16 = 6;
  localparam int F17_DLYRES = 7;
  localparam logic [7:0] LATCH17_MASK = 8'h1F;

  // field positions in the general status register
  localparam int GS_STBY = 0;
  localparam int GS_TMO = 1;
  localparam int GS_POR = 2;
  localparam int GS_ODIS = 3;
  localparam int GS_FAIL = 4;
  localparam int GS_OTEMP = 5;
  localparam int GS_GRP = 6;
  localparam int GS_DLY = 7;

  // reset values
  localparam logic [7:0] RST_FAULT = 8'hFF;
  localparam logic [4:0] RST_LATCH17 = 5'h1F;

  // timing
  localparam int MCLK_MHZ = 20;
  localparam int T_DLY_GLITCH_NS = 2000;
  localparam int T_DLY_FILT_NS = 5000;
  localparam int T_GRP_FILT_NS = 5000;
  localparam int DLY_GLITCH_CYC = (T_DLY_GLITCH_NS * MCLK_MHZ + 999) / 1000;
  localparam int DLY_FILT_CYC = (T_DLY_FILT_NS * MCLK_MHZ + 999) / 1000;
  localparam int GRP_FILT_CYC = (T_GRP_FILT_NS * MCLK_MHZ + 999) / 1000;
  localparam int FILT_CNT_W = 12;

  // answer shift position within a frame
  localparam int RESP_LOAD_BIT = 2;

endpackage

// ===== rtl/ldsr_diag_regs.sv
`timescale 1ns/10ps
module ldsr_diag_regs
  import ldsr_pkg::*;
#(
  parameter int DLY_GLITCH = ldsr_pkg::DLY_GLITCH_CYC,
  parameter int DLY_FILT = ldsr_pkg::DLY_FILT_CYC,
  parameter int GRP_FILT = ldsr_pkg::GRP_FILT_CYC
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic por_active,
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_sdi,
  output logic link_sdo,
  input wire logic [19:0] chan_fault_code,
  input wire logic [17:0] stage_revcur,
  input wire logic ch15_live_off,
  input wire logic ch16_live_off,
  input wire logic output_disable_pin_n,
  input wire logic [17:0] stage_failure,
  input wire logic [17:0] diag_overtemp,
  input wire logic group_disable_pin,
  input wire logic delay_input_pin,
  input wire logic link_timeout_evt,
  output logic output_standby,
  output logic link_timeout_flag
);
  import ldsr_pkg::*;

  // counters saturate at their limit, so each limit must fit the counter
  if (DLY_GLITCH < 1 || DLY_FILT < 1 || GRP_FILT < 1) begin : g_cnt_low
    $error("filter counts must be at least one");
  end
  if (DLY_GLITCH >= 2 ** FILT_CNT_W || DLY_FILT >= 2 ** FILT_CNT_W ||
      GRP_FILT >= 2 ** FILT_CNT_W) begin : g_cnt_wide
    $error("filter counts exceed counter width");
  end

  // ---------------- link domain ----------------
  logic lrst_s1;
  logic lrst_s2;
  logic [4:0] bit_cnt;
  logic [16:0] rx_shift;
  logic [16:0] cmd_word;
  logic cmd_tgl;
  logic resp_tgl_s1;
  logic resp_tgl_s2;
  logic resp_seen;
  logic [7:0] tx_shift;
  logic resp_tgl;
  logic [7:0] resp_data;

  wire frame_done = link_frame && (bit_cnt == 5'(FRAME_BITS - 1));
  wire load_resp = link_frame && (bit_cnt == 5'(RESP_LOAD_BIT));
  wire resp_new = resp_tgl_s2 != resp_seen;

  // link reset taken from rstn; link_clk must tick while rstn is low
  always_ff @(posedge link_clk) begin
    lrst_s1 <= rstn;
    lrst_s2 <= lrst_s1;
  end

  // frame end clears the count even though link_clk stops between frames
  always_ff @(posedge link_clk or negedge link_frame) begin
    if (!link_frame) begin
      bit_cnt <= 5'h00;
    end else if (!lrst_s2) begin
      bit_cnt <= 5'h00;
    end else if (!frame_done) begin
      bit_cnt <= bit_cnt + 5'h01;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2) begin
      rx_shift <= 17'h00000;
    end else if (link_frame) begin
      rx_shift <= {rx_shift[15:0], link_sdi};
    end
  end

  // word held stable until the next frame ends, well after the mclk side samples it
  always_ff @(posedge link_clk) begin
    if (!lrst_s2) begin
      cmd_word <= 17'h00000;
      cmd_tgl <= 1'b0;
    end else if (frame_done) begin
      cmd_word <= {rx_shift[15:0], link_sdi};
      cmd_tgl <= ~cmd_tgl;
    end
  end

  always_ff @(posedge link_clk) begin
    if (!lrst_s2) begin
      resp_tgl_s1 <= 1'b0;
      resp_tgl_s2 <= 1'b0;
    end else begin
      resp_tgl_s1 <= resp_tgl;
      resp_tgl_s2 <= resp_tgl_s1;
    end
  end

  // answer of the previous read goes out in the following frame, low bit first
  always_ff @(posedge link_clk) begin
    if (!lrst_s2) begin
      resp_seen <= 1'b0;
      tx_shift <= RST_FAULT;
      link_sdo <= 1'b1;
    end else if (load_resp) begin
      resp_seen <= resp_tgl_s2;
      tx_shift <= resp_new ? {1'b1, resp_data[7:1]} : RST_FAULT;
      link_sdo <= resp_new ? resp_data[0] : 1'b1;
    end else if (link_frame) begin
      tx_shift <= {1'b1, tx_shift[7:1]};
      link_sdo <= tx_shift[0];
    end else begin
      link_sdo <= 1'b1;
    end
  end

  // ---------------- mclk domain ----------------
  logic cmd_s1;
  logic cmd_s2;
  logic cmd_s3;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_s1 <= 1'b0;
      cmd_s2 <= 1'b0;
      cmd_s3 <= 1'b0;
    end else begin
      cmd_s1 <= cmd_tgl;
      cmd_s2 <= cmd_s1;
      cmd_s3 <= cmd_s2;
    end
  end

  wire cmd_strobe = cmd_s2 != cmd_s3;
  wire [4:0] cmd_code = cmd_word[FRM_CODE_MSB:FRM_CODE_LSB];
  wire [7:0] cmd_sel = cmd_word[FRM_SEL_MSB:FRM_SEL_LSB];
  wire cmd_valid = cmd_strobe && cmd_word[FRM_TYPE_POS];
  wire is_read = cmd_valid && (cmd_code == CMD_RD_DATA);
  wire wr_rst = cmd_valid && (cmd_code == CMD_WR_RST);
  wire wr_start = cmd_valid && (cmd_code == CMD_WR_START);
  wire rd_9_12 = is_read && cmd_sel[SEL_FAULT_9_12];
  wire rd_13_16 = is_read && cmd_sel[SEL_FAULT_13_16];
  wire rd_17_18 = is_read && cmd_sel[SEL_FAULT_17_18];
  wire rd_gen = is_read && cmd_sel[SEL_GENERAL];
  wire rd_any = rd_9_12 || rd_13_16 || rd_17_18 || rd_gen;

  // pin synchronisers; stage 1 feeds stage 2 only
  localparam int SYN_W = 20 + 18 + 18 + 18 + 6;
  logic [SYN_W-1:0] syn1;
  logic [SYN_W-1:0] syn2;
  wire [SYN_W-1:0] syn_in = {chan_fault_code, stage_revcur, stage_failure, diag_overtemp,
    por_active, ch15_live_off, ch16_live_off, output_disable_pin_n, group_disable_pin,
    delay_input_pin};

  always_ff @(posedge mclk) begin
    syn1 <= syn_in;
    syn2 <= syn1;
  end

  wire [19:0] fault_live = syn2[SYN_W-1 -: 20];
  wire revcur_any = |syn2[SYN_W-21 -: 18];
  wire fail_any = |syn2[SYN_W-39 -: 18];
  wire dot_any = |syn2[SYN_W-57 -: 18];
  wire por_s = syn2[5];
  wire ch15_off_s = syn2[4];
  wire ch16_off_s = syn2[3];
  wire odis_n_s = syn2[2];
  wire grp_s = syn2[1];
  wire dly_s = syn2[0];

  // the latched fault bits of the 9-12, 13-16 and 17/18 registers also clear on soft reset; the general register and the delay-reset bit do not
  wire hard_clr = !rstn || por_s;
  wire soft_clr = hard_clr || wr_rst;

  // latched faults: a zero from a stage sticks; a read reloads the live code
  // so a fault present during the read is not lost
  function automatic logic [7:0] latch_fault(input logic [7:0] cur, input logic [7:0] live,
                                              input logic rd);
    latch_fault = rd ? live : (cur & live);
  endfunction

  logic [7:0] fault_9_12;
  logic [7:0] fault_13_16;
  logic [4:0] latch_17;

  wire [7:0] next_fault_9_12 = latch_fault(fault_9_12, fault_live[7:0], rd_9_12);
  wire [7:0] next_fault_13_16 = latch_fault(fault_13_16, fault_live[15:8], rd_13_16);
  wire [7:0] live_17 = {3'h7, ~revcur_any, fault_live[19:16]};
  wire [4:0] next_latch_17 = 5'(latch_fault({3'h7, latch_17}, live_17, rd_17_18));

  always_ff @(posedge mclk) begin
    if (soft_clr) begin
      fault_9_12 <= RST_FAULT;
      fault_13_16 <= RST_FAULT;
      latch_17 <= RST_LATCH17;
    end else begin
      fault_9_12 <= next_fault_9_12;
      fault_13_16 <= next_fault_13_16;
      latch_17 <= next_latch_17;
    end
  end

  // input filters
  logic [FILT_CNT_W-1:0] dly_hi_cnt;
  logic [FILT_CNT_W-1:0] dly_lo_cnt;
  logic [FILT_CNT_W-1:0] grp_hi_cnt;
  logic [FILT_CNT_W-1:0] grp_lo_cnt;
  logic dly_level;
  logic grp_level;
  logic dly_reset_level;

  function automatic logic [FILT_CNT_W-1:0] run_cnt(input logic [FILT_CNT_W-1:0] cnt,
                                                   input logic active, input int lim);
    if (!active) begin
      run_cnt = '0;
    end else if (cnt < FILT_CNT_W'(lim)) begin
      run_cnt = cnt + 1'b1;
    end else begin
      run_cnt = cnt;
    end
  endfunction

  wire dly_hi_done = dly_hi_cnt == FILT_CNT_W'(DLY_GLITCH);
  wire dly_lo_done = dly_lo_cnt == FILT_CNT_W'(DLY_FILT);
  wire grp_hi_done = grp_hi_cnt == FILT_CNT_W'(GRP_FILT);
  wire grp_lo_done = grp_lo_cnt == FILT_CNT_W'(GRP_FILT);

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dly_hi_cnt <= '0;
      dly_lo_cnt <= '0;
      grp_hi_cnt <= '0;
      grp_lo_cnt <= '0;
    end else begin
      dly_hi_cnt <= run_cnt(dly_hi_cnt, dly_s, DLY_GLITCH);
      dly_lo_cnt <= run_cnt(dly_lo_cnt, !dly_s, DLY_FILT);
      grp_hi_cnt <= run_cnt(grp_hi_cnt, grp_s, GRP_FILT);
      grp_lo_cnt <= run_cnt(grp_lo_cnt, !grp_s, GRP_FILT);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      dly_level <= 1'b0;
      grp_level <= 1'b0;
      dly_reset_level <= 1'b1;
    end else begin
      dly_level <= dly_hi_done ? 1'b1 : (dly_lo_done ? 1'b0 : dly_level);
      grp_level <= grp_hi_done ? 1'b1 : (grp_lo_done ? 1'b0 : grp_level);
      dly_reset_level <= dly_hi_done ? 1'b0 : (!dly_s ? 1'b1 : dly_reset_level);
    end
  end

  // general status flags
  logic por_flag;
  logic otemp_flag;

  always_ff @(posedge mclk) begin
    if (hard_clr) begin
      output_standby <= 1'b1;
    end else if (wr_start) begin
      output_standby <= 1'b0;
    end
  end

  // the event wins over a read in the same cycle
  always_ff @(posedge mclk) begin
    if (hard_clr) begin
      link_timeout_flag <= 1'b1;
    end else if (link_timeout_evt) begin
      link_timeout_flag <= 1'b0;
    end else if (rd_gen) begin
      link_timeout_flag <= 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      por_flag <= 1'b0;
    end else if (por_s) begin
      por_flag <= 1'b1;
    end else if (rd_gen) begin
      por_flag <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (hard_clr) begin
      otemp_flag <= 1'b1;
    end else if (dot_any) begin
      otemp_flag <= 1'b0;
    end else if (rd_gen) begin
      otemp_flag <= 1'b1;
    end
  end

  // unfiltered live bits are the synchronised inputs, two mclk late at most; delay and group bits also pass the filters
  wire [7:0] reg_17_18 = {dly_reset_level, ch16_off_s, ch15_off_s, latch_17};
  wire [7:0] reg_gen = {dly_level, grp_level, otemp_flag, ~fail_any, odis_n_s,
    por_flag, link_timeout_flag, output_standby};

  // one select bit expected; lowest set wins otherwise
  wire [7:0] rd_value = rd_9_12 ? fault_9_12 :
                        rd_13_16 ? fault_13_16 :
                        rd_17_18 ? reg_17_18 : reg_gen;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      resp_tgl <= 1'b0;
      resp_data <= RST_FAULT;
    end else if (rd_any) begin
      resp_tgl <= ~resp_tgl;
      resp_data <= rd_value;
    end
  end

endmodule

// ===== sim/ldsr_diag_regs_assertions.sv
`timescale 1ns/10ps
module ldsr_diag_regs_assertions (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic por_active,
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_sdo,
  input wire logic link_timeout_evt,
  input wire logic output_standby,
  input wire logic link_timeout_flag
);
  logic [4:0] fage;
  logic [4:0] rage;
  logic [4:0] lcnt;
  // saturating ages, so an old event cannot alias a new one
  always_ff @(posedge mclk) begin
    fage <= link_frame ? 5'h00 : (!rstn ? 5'h1F : fage + {4'h0, fage != 5'h1F});
    rage <= (!rstn || por_active) ? 5'h00 : rage + {4'h0, rage != 5'h1F};
  end
  // link clock stops between frames, so clear on frame end
  always_ff @(posedge link_clk or negedge link_frame) begin
    lcnt <= !link_frame ? 5'h00 : lcnt + {4'h0, lcnt != 5'h1F};
  end
  sequence s_por_hold;
    por_active [*3];
  endsequence
  a_rst_values: assert property (@(posedge mclk) !rstn |=> output_standby && link_timeout_flag)
    else $error("reset values wrong");
  a_por_restore: assert property (@(posedge mclk) disable iff (!rstn)
    s_por_hold |-> ##[1:3] (output_standby && link_timeout_flag)) else $error("por values wrong");
  a_tmo_drop: assert property (@(posedge mclk) disable iff (!rstn)
    link_timeout_evt |-> ##[1:3] !link_timeout_flag) else $error("timeout flag not dropped");
  a_tmo_fall_cause: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(link_timeout_flag) |-> $past(link_timeout_evt) || $past(link_timeout_evt, 2))
    else $error("timeout flag fell without event");
  a_tmo_rise_cause: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(link_timeout_flag) |-> fage < 5'd20 || rage < 5'd8)
    else $error("timeout flag rose without read");
  a_stby_rise_cause: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(output_standby) |-> rage < 5'd8) else $error("standby set without reset");
  a_stby_start_only: assert property (@(posedge mclk) disable iff (!rstn)
    $fell(output_standby) |-> fage < 5'd20) else $error("standby cleared without frame");
  a_sdo_idle: assert property (@(posedge mclk) disable iff (!rstn)
    !link_frame |-> link_sdo) else $error("answer line not idle");
  a_sdo_frame_idle: assert property (@(posedge link_clk) disable iff (!rstn)
    link_frame && (lcnt < 5'd3 || lcnt > 5'd10) |-> link_sdo) else $error("answer bit misplaced");
endmodule
bind ldsr_diag_regs ldsr_diag_regs_assertions u_chk (.mclk, .rstn, .por_active, .link_clk,
  .link_frame, .link_sdo, .link_timeout_evt, .output_standby, .link_timeout_flag);

// ===== sim/ldsr_host_model.sv
`timescale 1ns/10ps
module ldsr_host_model (
  output logic link_clk,
  output logic link_frame,
  output logic link_sdi,
  input wire logic link_sdo
);
  initial begin
    link_clk = 1'b0;
    link_frame = 1'b0;
    link_sdi = 1'b0;
  end
  // link side resets through a synchroniser, so reset needs edges
  task automatic clocks(input int n);
    repeat (n) begin
      #40 link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
  endtask
  // 17 bits first bit first; answer of the previous read comes back
  task automatic frame(input logic [16:0] cmd, output logic [7:0] ans);
    ans = 8'hFF;
    #17 link_frame = 1'b1;
    for (int k = 0; k < 17; k++) begin
      link_sdi = cmd[16 - k];
      #40;
      if (k > 2 && k < 11) ans[k - 3] = link_sdo;
      link_clk = 1'b1;
      #40 link_clk = 1'b0;
    end
    #40 link_frame = 1'b0;
    link_sdi = ~link_sdi;
    #1000;
  endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/10ps
module testbench;
  import ldsr_pkg::*;
  logic mclk = 1'b0;
  logic rstn, por_active, ch15_live_off, ch16_live_off, output_disable_pin_n;
  logic group_disable_pin, delay_input_pin, link_timeout_evt;
  logic [19:0] chan_fault_code;
  logic [17:0] stage_revcur, stage_failure, diag_overtemp;
  wire link_clk, link_frame, link_sdi, link_sdo, output_standby, link_timeout_flag;
  logic [31:0] seed = 32'hF1C40D2C;
  logic [31:0] r1, r2;
  logic [7:0] v;
  int err_count = 0;
  int n_tests = 0;
  always #25 mclk = ~mclk;
  ldsr_host_model host (.link_clk, .link_frame, .link_sdi, .link_sdo);
  ldsr_diag_regs #(.DLY_GLITCH(3), .DLY_FILT(3), .GRP_FILT(3)) DUT (.mclk, .rstn, .por_active,
    .link_clk, .link_frame, .link_sdi, .link_sdo, .chan_fault_code, .stage_revcur,
    .ch15_live_off, .ch16_live_off, .output_disable_pin_n, .stage_failure, .diag_overtemp,
    .group_disable_pin, .delay_input_pin, .link_timeout_evt, .output_standby,
    .link_timeout_flag);
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [7:0] exp_gen(input logic stby, tmo, por, ot);
    return {delay_input_pin, group_disable_pin, ot, ~|stage_failure, output_disable_pin_n,
      por, tmo, stby};
  endfunction
  function logic [7:0] exp17();
    return {~delay_input_pin, ch16_live_off, ch15_live_off, ~|stage_revcur,
      chan_fault_code[19:16]};
  endfunction
  task check(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task rd(input int sel, output logic [7:0] val);
    logic [7:0] d;
    host.frame({1'b1, CMD_RD_DATA, 8'h01 << sel, 3'h0}, d);
    host.frame(17'h00000, val);
  endtask
  task cmd(input logic [4:0] code);
    logic [7:0] d;
    host.frame({1'b1, code, 8'h00, 3'h0}, d);
  endtask
  task hold_reset(input logic por);
    @(posedge mclk);
    rstn <= por;
    por_active <= por;
    fork
      host.clocks(3);
    join_none
    cyc(5);
    rstn <= 1'b1;
    por_active <= 1'b0;
    host.clocks(4);
    cyc(5);
  endtask
  // about 140 frames of 2.4 us are expected
  initial begin
    #2000000;
    err_count++;
    conclude();
  end
  initial begin
    rstn = 1'b0;
    por_active = 1'b0;
    chan_fault_code = 20'hFFFFF;
    stage_revcur = 18'h0;
    ch15_live_off = 1'b0;
    ch16_live_off = 1'b0;
    output_disable_pin_n = 1'b1;
    stage_failure = 18'h0;
    diag_overtemp = 18'h0;
    group_disable_pin = 1'b0;
    delay_input_pin = 1'b0;
    link_timeout_evt = 1'b0;
    hold_reset(1'b0);
    rd(SEL_GENERAL, v);
    check(v, exp_gen(1'b1, 1'b1, 1'b0, 1'b1));
    $display("test reset done");
    repeat (5) begin
      r1 = rnd();
      r2 = rnd();
      @(posedge mclk);
      chan_fault_code <= r1[19:0];
      stage_revcur <= r2[0] ? r2[31:14] : 18'h0;
      ch15_live_off <= r1[20];
      ch16_live_off <= r1[21];
      output_disable_pin_n <= r1[22];
      stage_failure <= r1[23] ? r2[17:0] : 18'h0;
      group_disable_pin <= r1[24];
      delay_input_pin <= r1[25];
      cyc(20);
      // first pass drops faults latched before the change
      for (int s = SEL_FAULT_9_12; s <= SEL_GENERAL; s++) rd(s, v);
      rd(SEL_FAULT_9_12, v);
      check(v, chan_fault_code[7:0]);
      rd(SEL_FAULT_13_16, v);
      check(v, chan_fault_code[15:8]);
      rd(SEL_FAULT_17_18, v);
      check(v, exp17());
      rd(SEL_GENERAL, v);
      check(v, exp_gen(1'b1, 1'b1, 1'b0, 1'b1));
    end
    $display("test live done");
    @(posedge mclk);
    chan_fault_code <= 20'hFFFFF;
    cyc(10);
    rd(SEL_FAULT_9_12, v);
    rd(SEL_FAULT_13_16, v);
    for (int k = 0; k < 4; k++) begin
      @(posedge mclk);
      chan_fault_code <= {10{k[1:0]}};
      cyc(10);
      chan_fault_code <= 20'hFFFFF;
      cyc(10);
      for (int s = SEL_FAULT_9_12; s <= SEL_FAULT_13_16; s++) begin
        rd(s, v);
        check(v, {4{k[1:0]}});
        rd(s, v);
        check(v, RST_FAULT);
      end
    end
    // two select bits: lowest register answers, both clear
    @(posedge mclk);
    chan_fault_code <= 20'h0A5F0;
    cyc(10);
    chan_fault_code <= 20'hFFFFF;
    cyc(10);
    host.frame({1'b1, CMD_RD_DATA, (8'h01 << SEL_FAULT_9_12) | (8'h01 << SEL_FAULT_13_16),
      3'h0}, v);
    host.frame(17'h00000, v);
    check(v, 8'hF0);
    rd(SEL_FAULT_13_16, v);
    check(v, RST_FAULT);
    $display("test codes done");
    @(posedge mclk);
    diag_overtemp <= 18'h1 << (r1 % 18);
    link_timeout_evt <= 1'b1;
    @(posedge mclk);
    diag_overtemp <= 18'h0;
    link_timeout_evt <= 1'b0;
    cyc(5);
    check({7'h0, link_timeout_flag}, 8'h00);
    cmd(5'h00);
    check({7'h0, link_timeout_flag}, 8'h00);
    rd(SEL_GENERAL, v);
    check(v, exp_gen(1'b1, 1'b0, 1'b0, 1'b0));
    check({7'h0, link_timeout_flag}, 8'h01);
    rd(SEL_GENERAL, v);
    check(v, exp_gen(1'b1, 1'b1, 1'b0, 1'b1));
    $display("test latched flags done");
    @(posedge mclk);
    chan_fault_code <= 20'h00000;
    link_timeout_evt <= 1'b1;
    @(posedge mclk);
    link_timeout_evt <= 1'b0;
    cyc(5);
    chan_fault_code <= 20'hFFFFF;
    cyc(10);
    cmd(CMD_WR_RST);
    rd(SEL_FAULT_9_12, v);
    check(v, RST_FAULT);
    rd(SEL_GENERAL, v);
    check(v, exp_gen(1'b1, 1'b0, 1'b0, 1'b1));
    $display("test soft reset done");
    check({7'h0, output_standby}, 8'h01);
    cmd(CMD_WR_START);
    check({7'h0, output_standby}, 8'h00);
    rd(SEL_GENERAL, v);
    check(v, exp_gen(1'b0, 1'b1, 1'b0, 1'b1));
    hold_reset(1'b0);
    check({7'h0, output_standby}, 8'h01);
    $display("test start done");
    hold_reset(1'b1);
    rd(SEL_GENERAL, v);
    check(v, exp_gen(1'b1, 1'b1, 1'b1, 1'b1));
    rd(SEL_GENERAL, v);
    check(v, exp_gen(1'b1, 1'b1, 1'b0, 1'b1));
    $display("test power-on done");
    conclude();
  end
endmodule
